// [hdl/spp_pkg.sv]
// constants for the sector and password protection block
`default_nettype none
package spp_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int SPP_SECTORS = 1024;
    localparam int SPP_SEC_W = 10;
    localparam int SPP_SUBS = 16;
    localparam int SPP_SUB_W = 4;
    localparam int SPP_PM_W = 16;
    localparam int SPP_PW_W = 64;
    localparam int SPP_OP_W = 4;
    localparam logic [SPP_SEC_W-1:0] SPP_FIRST_SEC = 10'h000;
    localparam logic [SPP_SEC_W-1:0] SPP_LAST_SEC = 10'h3FF;
    // ****************************************
    // protection mode register
    // ****************************************
    localparam int SPP_PM_PW_BIT = 2;
    localparam int SPP_PM_SP_BIT = 1;
    localparam logic [SPP_PM_W-1:0] SPP_PM_RESET = 16'hFFFF;
    localparam logic [SPP_PM_W-1:0] SPP_PM_OTP = 16'h0006;
    // password value before programming, arbitrary
    localparam logic [SPP_PW_W-1:0] SPP_PW_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic SPP_FREEZE_OPEN = 1'b1;
    // ****************************************
    // command codes
    // ****************************************
    localparam logic [SPP_OP_W-1:0] SPP_OP_NOP = 4'h0;
    localparam logic [SPP_OP_W-1:0] SPP_OP_WR_PMODE = 4'h1;
    localparam logic [SPP_OP_W-1:0] SPP_OP_RD_PMODE = 4'h2;
    localparam logic [SPP_OP_W-1:0] SPP_OP_WR_PW = 4'h3;
    localparam logic [SPP_OP_W-1:0] SPP_OP_RD_PW = 4'h4;
    localparam logic [SPP_OP_W-1:0] SPP_OP_UNLOCK = 4'h5;
    localparam logic [SPP_OP_W-1:0] SPP_OP_WR_FRZ = 4'h6;
    localparam logic [SPP_OP_W-1:0] SPP_OP_RD_FRZ = 4'h7;
    localparam logic [SPP_OP_W-1:0] SPP_OP_WR_NVL = 4'h8;
    localparam logic [SPP_OP_W-1:0] SPP_OP_ER_NVL = 4'h9;
    localparam logic [SPP_OP_W-1:0] SPP_OP_RD_NVL = 4'hA;
    localparam logic [SPP_OP_W-1:0] SPP_OP_WR_VL = 4'hB;
    localparam logic [SPP_OP_W-1:0] SPP_OP_RD_VL = 4'hC;
    localparam logic [SPP_OP_W-1:0] SPP_OP_CHECK = 4'hD;
endpackage
`default_nettype wire

// [hdl/spp_sector_protect.sv]
// sector and password protection logic
`default_nettype none
module spp_sector_protect
    import spp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic porN,
    input wire logic cmdValid,
    input wire logic [SPP_OP_W-1:0] cmdOp,
    input wire logic [SPP_SEC_W-1:0] cmdSector,
    input wire logic [SPP_SUB_W-1:0] cmdSub,
    input wire logic [SPP_PW_W-1:0] cmdData,
    output logic rspValid,
    output logic rspOk,
    output logic [SPP_PW_W-1:0] rspData,
    output logic freezeBit,
    output logic pwModeOn
);
    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic isEdge(input logic [SPP_SEC_W-1:0] s);
        return (s == SPP_FIRST_SEC) || (s == SPP_LAST_SEC);
    endfunction

    function automatic logic edgeIdx(input logic [SPP_SEC_W-1:0] s);
        return s == SPP_LAST_SEC;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [SPP_PM_W-1:0] pmode_q;
    logic [SPP_PW_W-1:0] pw_q;
    logic [SPP_SECTORS-1:0] nvLock_q;
    logic [SPP_SECTORS-1:0] wrLock_q;
    logic [SPP_SECTORS-1:0] down_q;
    logic [1:0][SPP_SUBS-1:0] subWr_q;
    logic [1:0][SPP_SUBS-1:0] subDown_q;
    logic freeze_q;
    logic initDone_q;
    logic rspValid_q;
    logic rspOk_q;
    logic [SPP_PW_W-1:0] rspData_q;
    logic volRstN;

    // volatile state also clears on power loss
    assign volRstN = nrst & porN;

    // ****************************************
    // decode
    // ****************************************
    logic opWrPm, opRdPm, opWrPw, opRdPw, opUnlock, opWrFrz, opRdFrz;
    logic opWrNvl, opErNvl, opRdNvl, opWrVl, opRdVl, opCheck;
    assign opWrPm = cmdValid && cmdOp == SPP_OP_WR_PMODE;
    assign opRdPm = cmdValid && cmdOp == SPP_OP_RD_PMODE;
    assign opWrPw = cmdValid && cmdOp == SPP_OP_WR_PW;
    assign opRdPw = cmdValid && cmdOp == SPP_OP_RD_PW;
    assign opUnlock = cmdValid && cmdOp == SPP_OP_UNLOCK;
    assign opWrFrz = cmdValid && cmdOp == SPP_OP_WR_FRZ;
    assign opRdFrz = cmdValid && cmdOp == SPP_OP_RD_FRZ;
    assign opWrNvl = cmdValid && cmdOp == SPP_OP_WR_NVL;
    assign opErNvl = cmdValid && cmdOp == SPP_OP_ER_NVL;
    assign opRdNvl = cmdValid && cmdOp == SPP_OP_RD_NVL;
    assign opWrVl = cmdValid && cmdOp == SPP_OP_WR_VL;
    assign opRdVl = cmdValid && cmdOp == SPP_OP_RD_VL;
    assign opCheck = cmdValid && cmdOp == SPP_OP_CHECK;

    logic pwOn, spOff, modeFixed, freezeNow, pwMatch;
    assign pwOn = ~pmode_q[SPP_PM_PW_BIT];
    assign spOff = ~pmode_q[SPP_PM_SP_BIT];
    assign modeFixed = pwOn | spOff;
    // freeze locked out of reset in password mode
    assign freezeNow = initDone_q ? freeze_q : ~pwOn;
    assign pwMatch = cmdData == pw_q;

    // one-time mode bits: only ones to zeros, at most one zero
    logic [SPP_PM_W-1:0] pmNew;
    logic pmOk;
    assign pmNew = pmode_q & (cmdData[SPP_PM_W-1:0] | ~SPP_PM_OTP);
    assign pmOk = !modeFixed && (pmNew[SPP_PM_PW_BIT] | pmNew[SPP_PM_SP_BIT]);

    logic edgeSel, edgeSec;
    logic curWr, curDown, curNv, grant;
    assign edgeSec = isEdge(cmdSector);
    assign edgeSel = edgeIdx(cmdSector);
    assign curNv = nvLock_q[cmdSector];
    assign curWr = edgeSec ? subWr_q[edgeSel][cmdSub] : wrLock_q[cmdSector];
    assign curDown = edgeSec ? subDown_q[edgeSel][cmdSub] : down_q[cmdSector];
    assign grant = curNv && !curWr;

    logic pwWrOk, unlockOk, nvlOk, vlOk;
    assign pwWrOk = !pwOn;
    assign unlockOk = !pwOn || pwMatch;
    assign nvlOk = freezeNow;
    assign vlOk = !curDown;

    // ****************************************
    // nonvolatile store
    // ****************************************
    always_ff @(posedge clk_sys or negedge porN) begin
        if (!porN) begin
            pmode_q <= SPP_PM_RESET;
            pw_q <= SPP_PW_RESET;
        end else begin
            if (opWrPm && pmOk) begin
                pmode_q <= pmNew;
            end
            if (opWrPw && pwWrOk) begin
                pw_q <= cmdData;
            end
        end
    end

    // factory state unlocked; kept over device reset
    always_ff @(posedge clk_sys or negedge porN) begin
        if (!porN) begin
            nvLock_q <= '1;
        end else if (opErNvl && nvlOk) begin
            nvLock_q <= '1;
        end else if (opWrNvl && nvlOk) begin
            nvLock_q[cmdSector] <= 1'b0;
        end
    end

    // ****************************************
    // volatile store
    // ****************************************
    always_ff @(posedge clk_sys or negedge volRstN) begin
        if (!volRstN) begin
            freeze_q <= SPP_FREEZE_OPEN;
            initDone_q <= 1'b0;
        end else begin
            initDone_q <= 1'b1;
            if (opWrFrz) begin
                freeze_q <= 1'b0;
            end else if (opUnlock && unlockOk) begin
                freeze_q <= 1'b1;
            end else begin
                freeze_q <= freezeNow;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge volRstN) begin
        if (!volRstN) begin
            wrLock_q <= '0;
            down_q <= '0;
            subWr_q <= '0;
            subDown_q <= '0;
        end else if (opWrVl && vlOk) begin
            if (edgeSec) begin
                subWr_q[edgeSel][cmdSub] <= cmdData[0];
                subDown_q[edgeSel][cmdSub] <= cmdData[1];
            end else begin
                wrLock_q[cmdSector] <= cmdData[0];
                down_q[cmdSector] <= cmdData[1];
            end
        end
    end

    // ****************************************
    // answer
    // ****************************************
    logic ackNow;
    logic [SPP_PW_W-1:0] dataNow;
    assign ackNow = (opWrPm & pmOk) | opRdPm | (opWrPw & pwWrOk) | (opRdPw & !pwOn)
        | (opUnlock & unlockOk) | opWrFrz | opRdFrz | ((opWrNvl | opErNvl) & nvlOk)
        | opRdNvl | (opWrVl & vlOk) | opRdVl | (opCheck & grant);
    // hidden password reads as zero in password mode
    assign dataNow = opRdPm ? {{(SPP_PW_W-SPP_PM_W){1'b0}}, pmode_q}
        : (opRdPw && !pwOn) ? pw_q
        : opRdFrz ? {{(SPP_PW_W-1){1'b0}}, freezeNow}
        : opRdNvl ? {{(SPP_PW_W-1){1'b0}}, curNv}
        : opRdVl ? {{(SPP_PW_W-2){1'b0}}, curDown, curWr}
        : '0;

    always_ff @(posedge clk_sys or negedge volRstN) begin
        if (!volRstN) begin
            rspValid_q <= 1'b0;
            rspOk_q <= 1'b0;
            rspData_q <= '0;
        end else begin
            rspValid_q <= cmdValid && cmdOp != SPP_OP_NOP;
            rspOk_q <= ackNow;
            rspData_q <= dataNow;
        end
    end

    assign rspValid = rspValid_q;
    assign rspOk = rspOk_q;
    assign rspData = rspData_q;
    assign freezeBit = freezeNow;
    assign pwModeOn = pwOn;

    // ****************************************
    // checks
    // ****************************************
    sequence unlockGood;
        opUnlock && pwOn && pwMatch;
    endsequence

    sequence unlockBad;
        opUnlock && pwOn && !pwMatch && !opWrFrz;
    endsequence

    sequence answeredNo;
        rspValid && !rspOk;
    endsequence

    pm_fixed_bits_a: assert property (@(posedge clk_sys) disable iff (!porN)
        (pmode_q | SPP_PM_OTP) == SPP_PM_RESET)
        else $error("protection register fixed bits not one");

    pm_exclusive_a: assert property (@(posedge clk_sys) disable iff (!porN)
        pmode_q[SPP_PM_PW_BIT] || pmode_q[SPP_PM_SP_BIT])
        else $error("both protection mode bits zero");

    pm_once_a: assert property (@(posedge clk_sys) disable iff (!porN)
        modeFixed |=> $stable(pmode_q))
        else $error("protection mode changed after fixing");

    pw_frozen_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrPw && pwOn |=> answeredNo and $stable(pw_q))
        else $error("password changed in password mode");

    pw_hidden_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opRdPw && pwOn |=> answeredNo and rspData == '0)
        else $error("password read back in password mode");

    unlock_good_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        unlockGood and !opWrFrz |=> freezeBit && rspOk)
        else $error("correct password did not open freeze");

    unlock_bad_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        unlockBad |=> $stable(freezeBit) and answeredNo)
        else $error("wrong password changed freeze");

    freeze_write_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrFrz |=> !freezeBit [*2] or (!freezeBit ##1 $past(opUnlock)))
        else $error("write freeze did not close freeze");

    freeze_reset_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        !initDone_q && !cmdValid |=> freezeBit == !pwModeOn)
        else $error("freeze wrong after reset");

    freeze_read_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opRdFrz |=> rspData[0] == $past(freezeNow) && rspOk)
        else $error("freeze read mismatch");

    nv_guard_a: assert property (@(posedge clk_sys) disable iff (!porN)
        (opWrNvl || opErNvl) && !freezeNow |=> $stable(nvLock_q))
        else $error("nonvolatile locks changed while frozen");

    nv_erase_a: assert property (@(posedge clk_sys) disable iff (!porN)
        opErNvl && freezeNow |=> nvLock_q == '1)
        else $error("erase did not unlock all sectors");

    vl_down_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrVl && curDown |=> $stable(wrLock_q) && $stable(subWr_q) && $stable(down_q))
        else $error("locked-down volatile bits written");

    check_grant_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opCheck && (!curNv || curWr) |=> answeredNo)
        else $error("program granted to locked sector");

    sequence answeredYes;
        rspValid && rspOk;
    endsequence

    sequence frzRise;
        pwModeOn && !freezeBit ##1 freezeBit;
    endsequence

    nv_write_a: assert property (@(posedge clk_sys) disable iff (!porN)
        opWrNvl && freezeNow |=> !nvLock_q[$past(cmdSector)])
        else $error("nonvolatile lock not set");

    nv_keep_a: assert property (@(posedge clk_sys) disable iff (!porN)
        !((opWrNvl || opErNvl) && freezeNow) |=> $stable(nvLock_q))
        else $error("nonvolatile locks changed without command");

    nv_refuse_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        (opWrNvl || opErNvl) && !freezeNow |=> answeredNo)
        else $error("nonvolatile lock change accepted while frozen");

    nv_read_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opRdNvl |=> rspData[0] == $past(curNv) and answeredYes)
        else $error("nonvolatile lock read mismatch");

    check_open_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opCheck && grant |=> answeredYes)
        else $error("program refused to open sector");

    vl_write_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrVl && !edgeSec && !curDown |=> wrLock_q[$past(cmdSector)] == $past(cmdData[0]))
        else $error("write lock not stored");

    sub_only_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrVl && edgeSec |=> $stable(wrLock_q) && $stable(down_q))
        else $error("subsector write touched sector locks");

    down_hold_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrVl && edgeSec && curDown |=> $stable(subWr_q) && $stable(subDown_q))
        else $error("locked-down subsector bits written");

    pw_write_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrPw && !pwOn |=> pw_q == $past(cmdData) and answeredYes)
        else $error("password not stored");

    pm_refuse_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opWrPm && modeFixed |=> $stable(pmode_q) and answeredNo)
        else $error("fixed protection mode rewritten");

    unlock_free_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        opUnlock && !pwOn |=> freezeBit and answeredYes)
        else $error("unlock outside password mode failed");

    freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        !opWrFrz && !opUnlock |=> $stable(freezeBit))
        else $error("freeze changed without command");

    freeze_rise_a: assert property (@(posedge clk_sys) disable iff (!volRstN)
        frzRise |-> $past(opUnlock && pwMatch))
        else $error("freeze opened without password");
endmodule
`default_nettype wire

// [tb/spp_host_model.sv]
// host controller model issuing protection commands
`default_nettype none
module spp_host_model
    import spp_pkg::*;
(
    input wire logic clk_sys,
    output logic cmdValid,
    output logic [SPP_OP_W-1:0] cmdOp,
    output logic [SPP_SEC_W-1:0] cmdSector,
    output logic [SPP_SUB_W-1:0] cmdSub,
    output logic [SPP_PW_W-1:0] cmdData,
    input wire logic rspValid,
    input wire logic rspOk,
    input wire logic [SPP_PW_W-1:0] rspData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // one command, answer taken one edge later
    // ****************************************
    initial begin
        cmdValid = 1'b0;
        cmdOp = SPP_OP_NOP;
        cmdSector = '0;
        cmdSub = '0;
        cmdData = '0;
    end
    task automatic issue(input logic [SPP_OP_W-1:0] op, input logic [SPP_SEC_W-1:0] sec,
                         input logic [SPP_SUB_W-1:0] sub, input logic [SPP_PW_W-1:0] data,
                         output logic ok, output logic [SPP_PW_W-1:0] rd);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdSector <= sec;
        cmdSub <= sub;
        cmdData <= data;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        cmdOp <= SPP_OP_NOP;
        cmdSector <= ~sec;
        cmdSub <= ~sub;
        cmdData <= ~data;
        #1;
        ok = (rspValid === 1'b1) ? rspOk : 1'bx;
        rd = rspData;
    endtask
endmodule
`default_nettype wire

// [tb/spp_sector_protect_test.sv]
// self-checking bench for the sector and password protection block
`default_nettype none
module spp_sector_protect_test
    import spp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [SPP_PW_W-1:0] PW = 64'h0123_4567_89AB_CDEF;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic porN = 1'b0;
    logic cmdValid, rspValid, rspOk, freezeBit, pwModeOn;
    logic [SPP_OP_W-1:0] cmdOp;
    logic [SPP_SEC_W-1:0] cmdSector;
    logic [SPP_SUB_W-1:0] cmdSub;
    logic [SPP_PW_W-1:0] cmdData, rspData;
    int nErrors = 0;
    int checksDone = 0;
    always #10 clk_sys = ~clk_sys;
    spp_host_model i_host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSector(cmdSector),
        .cmdSub(cmdSub), .cmdData(cmdData), .rspValid(rspValid), .rspOk(rspOk), .rspData(rspData));
    spp_sector_protect i_dut (.clk_sys(clk_sys), .nrst(nrst), .porN(porN), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdSector(cmdSector), .cmdSub(cmdSub), .cmdData(cmdData), .rspValid(rspValid), .rspOk(rspOk),
        .rspData(rspData), .freezeBit(freezeBit), .pwModeOn(pwModeOn));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [SPP_PW_W-1:0] got, input logic [SPP_PW_W-1:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [SPP_OP_W-1:0] op, input logic [SPP_SEC_W-1:0] sec,
                       input logic [SPP_PW_W-1:0] data, input logic ok, input logic [SPP_PW_W-1:0] rd,
                       input logic [SPP_SUB_W-1:0] sub = '0);
        logic gotOk;
        logic [SPP_PW_W-1:0] gotData;
        i_host.issue(op, sec, sub, data, gotOk, gotData);
        chk({63'h0, gotOk}, {63'h0, ok}, "accept flag");
        chk(gotData, rd, "response data");
    endtask
    task automatic flags(input logic frz, input logic pw);
        chk({63'h0, freezeBit}, {63'h0, frz}, "freeze level");
        chk({63'h0, pwModeOn}, {63'h0, pw}, "password mode level");
    endtask
    task automatic resetPulse(input logic por);
        @(posedge clk_sys);
        nrst <= 1'b0;
        porN <= ~por;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        porN <= 1'b1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic testVolatile();
        cmd(SPP_OP_RD_FRZ, '0, '0, 1'b1, 64'h1);
        flags(1'b1, 1'b0);
        cmd(SPP_OP_WR_VL, 10'd5, 64'h1, 1'b1, '0);
        cmd(SPP_OP_CHECK, 10'd5, '0, 1'b0, '0);
        cmd(SPP_OP_CHECK, 10'd6, '0, 1'b1, '0);
        cmd(SPP_OP_WR_VL, SPP_LAST_SEC, 64'h1, 1'b1, '0, 4'h3);
        cmd(SPP_OP_CHECK, SPP_LAST_SEC, '0, 1'b0, '0, 4'h3);
        cmd(SPP_OP_CHECK, SPP_LAST_SEC, '0, 1'b1, '0, 4'h4);
        cmd(SPP_OP_WR_VL, 10'd5, 64'h3, 1'b1, '0);
        cmd(SPP_OP_WR_VL, 10'd5, 64'h0, 1'b0, '0);
        cmd(SPP_OP_RD_VL, 10'd5, '0, 1'b1, 64'h3);
        cmd(SPP_OP_WR_VL, SPP_LAST_SEC, 64'h3, 1'b1, '0, 4'h5);
        cmd(SPP_OP_WR_VL, SPP_LAST_SEC, 64'h0, 1'b0, '0, 4'h5);
        cmd(SPP_OP_RD_VL, SPP_LAST_SEC, '0, 1'b1, 64'h3, 4'h5);
        cmd(SPP_OP_RD_VL, SPP_FIRST_SEC, '0, 1'b1, 64'h0, 4'h5);
        resetPulse(1'b0);
        cmd(SPP_OP_RD_VL, 10'd5, '0, 1'b1, 64'h0);
        cmd(SPP_OP_CHECK, SPP_LAST_SEC, '0, 1'b1, '0, 4'h3);
        cmd(SPP_OP_RD_VL, SPP_LAST_SEC, '0, 1'b1, 64'h0, 4'h5);
    endtask
    task automatic testNonvolatile();
        cmd(SPP_OP_WR_NVL, 10'd7, '0, 1'b1, '0);
        cmd(SPP_OP_RD_NVL, 10'd7, '0, 1'b1, 64'h0);
        cmd(SPP_OP_CHECK, 10'd7, '0, 1'b0, '0);
        cmd(SPP_OP_WR_NVL, SPP_FIRST_SEC, '0, 1'b1, '0);
        cmd(SPP_OP_CHECK, SPP_FIRST_SEC, '0, 1'b0, '0, 4'hA);
        cmd(SPP_OP_WR_FRZ, '0, '0, 1'b1, '0);
        flags(1'b0, 1'b0);
        cmd(SPP_OP_RD_FRZ, '0, '0, 1'b1, 64'h0);
        cmd(SPP_OP_WR_NVL, 10'd9, '0, 1'b0, '0);
        cmd(SPP_OP_ER_NVL, '0, '0, 1'b0, '0);
        resetPulse(1'b0);
        cmd(SPP_OP_RD_NVL, 10'd7, '0, 1'b1, 64'h0);
        cmd(SPP_OP_RD_FRZ, '0, '0, 1'b1, 64'h1);
        cmd(SPP_OP_ER_NVL, '0, '0, 1'b1, '0);
        cmd(SPP_OP_CHECK, 10'd7, '0, 1'b1, '0);
        cmd(SPP_OP_CHECK, SPP_FIRST_SEC, '0, 1'b1, '0, 4'hA);
        cmd(SPP_OP_WR_FRZ, '0, '0, 1'b1, '0);
        cmd(SPP_OP_UNLOCK, '0, '0, 1'b1, '0);
        flags(1'b1, 1'b0);
    endtask
    task automatic testSectorMode();
        resetPulse(1'b1);
        cmd(SPP_OP_RD_PMODE, '0, '0, 1'b1, 64'hFFFF);
        cmd(SPP_OP_WR_PMODE, '0, 64'h0005, 1'b1, '0);
        cmd(SPP_OP_WR_PMODE, '0, 64'hFFFB, 1'b0, '0);
        cmd(SPP_OP_RD_PMODE, '0, '0, 1'b1, 64'hFFFD);
        flags(1'b1, 1'b0);
    endtask
    task automatic testPassword();
        resetPulse(1'b1);
        cmd(SPP_OP_RD_NVL, 10'd7, '0, 1'b1, 64'h1);
        cmd(SPP_OP_WR_PMODE, '0, 64'hFFF9, 1'b0, '0);
        cmd(SPP_OP_WR_PW, '0, PW, 1'b1, '0);
        cmd(SPP_OP_RD_PW, '0, '0, 1'b1, PW);
        cmd(SPP_OP_WR_PMODE, '0, 64'hFFFB, 1'b1, '0);
        cmd(SPP_OP_RD_PW, '0, '0, 1'b0, '0);
        cmd(SPP_OP_WR_PW, '0, ~PW, 1'b0, '0);
        cmd(SPP_OP_WR_PMODE, '0, 64'hFFFD, 1'b0, '0);
        resetPulse(1'b0);
        cmd(SPP_OP_RD_FRZ, '0, '0, 1'b1, 64'h0);
        cmd(SPP_OP_WR_NVL, 10'd3, '0, 1'b0, '0);
        cmd(SPP_OP_UNLOCK, '0, ~PW, 1'b0, '0);
        cmd(SPP_OP_WR_NVL, 10'd3, '0, 1'b0, '0);
        flags(1'b0, 1'b1);
        cmd(SPP_OP_UNLOCK, '0, PW, 1'b1, '0);
        flags(1'b1, 1'b1);
        cmd(SPP_OP_WR_NVL, 10'd3, '0, 1'b1, '0);
    endtask
    // ****************************************
    // run and verdict
    // ****************************************
    task automatic giveVerdict();
        if (nErrors == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        porN <= 1'b1;
        testVolatile();
        testNonvolatile();
        testSectorMode();
        testPassword();
        giveVerdict();
    end
    initial begin
        #200000;
        nErrors++;
        giveVerdict();
    end
endmodule
`default_nettype wire
